// *** logic/bpcf_consts.vh ***
// constants for the buck phase / capacitor / frequency boot setup register
// assumes: included by the design files by bare name
`ifndef BPCF_CONSTS_VH
`define BPCF_CONSTS_VH

// printed offset is not a multiple of four: it is the register index
`define BPCF_SETUP_INDEX 16'h7813
`define BPCF_SETUP_ADDR 18'h1E04C
`define BPCF_ADDR_W 18

`define BPCF_CONV4_INVERT_BIT 15
`define BPCF_CONV3_INVERT_BIT 14
`define BPCF_CONV2_INVERT_BIT 13
`define BPCF_CONV1_INVERT_BIT 12
`define BPCF_PHASE_MASK 16'hF000
`define BPCF_LOAD_ONLY_MASK 16'h0FFF
`define BPCF_SETUP_RESET 16'h2000

`define BPCF_CAP_SMALL_A 2'h0
`define BPCF_CAP_SMALL_B 2'h1
`define BPCF_CAP_MIDDLE 2'h2
`define BPCF_CAP_LARGE 2'h3
`define BPCF_RATE_2MHZ 2'h1
`define BPCF_RATE_4MHZ 2'h2

`define BPCF_RESP_OKAY 2'h0
`define BPCF_RESP_SLVERR 2'h2

`endif

// *** logic/bpcf_setup_store.v ***
// storage for the 16-bit boot setup word
// assumes: one write source chosen by the top; bit masks select fields
`include "bpcf_consts.vh"

module bpcf_setup_store (
    // clock and reset
    input wire clk_in,
    input wire reset_n_in,
    // write side
    input wire wr_en_in,
    input wire [15:0] wr_mask_in,
    input wire [15:0] wr_data_in,
    // stored word
    output reg [15:0] word_out
);

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            word_out <= `BPCF_SETUP_RESET;
        end else if (wr_en_in) begin
            word_out <= (word_out & ~wr_mask_in) | (wr_data_in & wr_mask_in);
        end
    end

endmodule

// *** logic/bpcf_top.v ***
// AXI4-Lite slave holding the buck converter boot setup register
// assumes: boot loader pulses load_valid_in with a full word from the
// non-volatile store or the external configuration memory
//
// Overview of operation
// - bits 15..12 invert the clock phase of converters four, three, two, one.
// - reset sets converter two phase inverted, other phases normal.
// - converter four/three capacitor codes at 11:10 and 9:8, reset 00.
// - converter two/one capacitor codes at 7:6 and 5:4, reset 00; only 10 valid, other codes pass through unchecked.
// - converter two/one switch rate codes at 3:2 and 1:0; 01 2MHz, 10 4MHz.
// - capacitor and rate fields change only during a configuration load.
`include "bpcf_consts.vh"

module bpcf_top (
    // clock and reset
    input wire clk_in,
    input wire reset_n_in,
    // axi4-lite write address
    input wire s_axi_awvalid_in,
    output reg s_axi_awready_out,
    input wire [17:0] s_axi_awaddr_in,
    // axi4-lite write data
    input wire s_axi_wvalid_in,
    output reg s_axi_wready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    // axi4-lite write response
    output reg s_axi_bvalid_out,
    input wire s_axi_bready_in,
    output reg [1:0] s_axi_bresp_out,
    // axi4-lite read address
    input wire s_axi_arvalid_in,
    output reg s_axi_arready_out,
    input wire [17:0] s_axi_araddr_in,
    // axi4-lite read data
    output reg s_axi_rvalid_out,
    input wire s_axi_rready_in,
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    // configuration load from the boot store
    input wire load_valid_in,
    input wire external_eeprom_config_in,
    input wire [15:0] load_data_in,
    // field outputs to the converters
    output reg conv1_clock_invert_out,
    output reg conv2_clock_invert_out,
    output reg conv3_clock_invert_out,
    output reg conv4_clock_invert_out,
    output reg [1:0] conv1_output_cap_range_out,
    output reg [1:0] conv2_output_cap_range_out,
    output reg [1:0] conv3_output_cap_range_out,
    output reg [1:0] conv4_output_cap_range_out,
    output reg [1:0] conv1_switch_rate_out,
    output reg [1:0] conv2_switch_rate_out,
    output reg load_from_eeprom_out
);

    function addr_hit;
        input [17:0] addr;
        begin
            addr_hit = (addr[17:2] == `BPCF_SETUP_INDEX);
        end
    endfunction

    // unmapped offsets answer with an error and leave the register alone
    function [1:0] resp_code;
        input [17:0] addr;
        begin
            resp_code = addr_hit(addr) ? `BPCF_RESP_OKAY : `BPCF_RESP_SLVERR;
        end
    endfunction

    // only the high byte lane carries phase bits; the low lane is all load-only
    function [15:0] host_mask;
        input [1:0] strb;
        begin
            host_mask = `BPCF_PHASE_MASK & {{8{strb[1]}}, {8{strb[0]}}};
        end
    endfunction

    reg aw_held_reg;
    reg w_held_reg;
    reg [17:0] aw_addr_reg;
    reg [15:0] w_data_reg;
    reg [1:0] w_strb_reg;
    wire [15:0] word;
    reg store_en;
    reg [15:0] store_mask;
    reg [15:0] store_data;
    wire host_write;
    wire aw_take;
    wire w_take;
    wire ar_take;
    wire b_done;
    wire r_done;

    assign host_write = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
    // each ready is a one-cycle pulse, so a held valid is not taken twice
    assign aw_take = s_axi_awvalid_in && !aw_held_reg && !s_axi_awready_out;
    assign w_take = s_axi_wvalid_in && !w_held_reg && !s_axi_wready_out;
    assign ar_take = s_axi_arvalid_in && !s_axi_rvalid_out && !s_axi_arready_out;
    assign b_done = s_axi_bvalid_out && s_axi_bready_in;
    assign r_done = s_axi_rvalid_out && s_axi_rready_in;

    // a boot load takes priority; a host write waits one cycle behind it
    always @* begin
        store_en = 1'b0;
        store_mask = 16'h0000;
        store_data = load_data_in;
        if (load_valid_in) begin
            store_en = 1'b1;
            store_mask = 16'hFFFF;
        end else if (host_write && addr_hit(aw_addr_reg)) begin
            store_en = 1'b1;
            store_mask = host_mask(w_strb_reg);
            store_data = w_data_reg;
        end
    end

    bpcf_setup_store u_store (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .wr_en_in(store_en),
        .wr_mask_in(store_mask),
        .wr_data_in(store_data),
        .word_out(word)
    );

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `BPCF_RESP_OKAY;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 18'h00000;
            w_data_reg <= 16'h0000;
            w_strb_reg <= 2'h0;
        end else begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            if (aw_take) begin
                s_axi_awready_out <= 1'b1;
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_in;
            end
            if (w_take) begin
                s_axi_wready_out <= 1'b1;
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_in[15:0];
                w_strb_reg <= s_axi_wstrb_in[1:0];
            end
            // a write colliding with a boot load is retried next cycle
            if (host_write && !load_valid_in) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= resp_code(aw_addr_reg);
            end
            if (b_done) begin
                s_axi_bvalid_out <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
            end
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `BPCF_RESP_OKAY;
        end else begin
            s_axi_arready_out <= 1'b0;
            if (ar_take) begin
                s_axi_arready_out <= 1'b1;
                s_axi_rvalid_out <= 1'b1;
                s_axi_rresp_out <= resp_code(s_axi_araddr_in);
                if (addr_hit(s_axi_araddr_in)) begin
                    s_axi_rdata_out <= {16'h0000, word};
                end else begin
                    s_axi_rdata_out <= 32'h00000000;
                end
            end else if (r_done) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // field outputs follow the stored word one cycle later
    // reserved capacitor and rate codes pass through unchecked; the boot image is trusted
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            conv4_clock_invert_out <= 1'b0;
            conv3_clock_invert_out <= 1'b0;
            conv2_clock_invert_out <= 1'b1;
            conv1_clock_invert_out <= 1'b0;
            conv4_output_cap_range_out <= 2'h0;
            conv3_output_cap_range_out <= 2'h0;
            conv2_output_cap_range_out <= 2'h0;
            conv1_output_cap_range_out <= 2'h0;
            conv2_switch_rate_out <= 2'h0;
            conv1_switch_rate_out <= 2'h0;
            load_from_eeprom_out <= 1'b0;
        end else begin
            conv4_clock_invert_out <= word[`BPCF_CONV4_INVERT_BIT];
            conv3_clock_invert_out <= word[`BPCF_CONV3_INVERT_BIT];
            conv2_clock_invert_out <= word[`BPCF_CONV2_INVERT_BIT];
            conv1_clock_invert_out <= word[`BPCF_CONV1_INVERT_BIT];
            conv4_output_cap_range_out <= word[11:10];
            conv3_output_cap_range_out <= word[9:8];
            conv2_output_cap_range_out <= word[7:6];
            conv1_output_cap_range_out <= word[5:4];
            conv2_switch_rate_out <= word[3:2];
            conv1_switch_rate_out <= word[1:0];
            if (load_valid_in) begin
                load_from_eeprom_out <= external_eeprom_config_in;
            end
        end
    end

endmodule

// *** dv/bpcf_boot_model.sv ***
// boot store model: one full-word load pulse per call
// assumes: caller is synced to clk_in
module bpcf_boot_model (
    // load bus
    input wire logic clk_in,
    output logic load_valid_in = 1'b0,
    output logic external_eeprom_config_in = 1'b0,
    output logic [15:0] load_data_in = 16'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic load(input logic [15:0] w, input logic src);
        @(posedge clk_in);
        load_valid_in <= 1'b1;
        load_data_in <= w;
        external_eeprom_config_in <= src;
        @(posedge clk_in);
        load_valid_in <= 1'b0;
        // stale word inverted so a late sample cannot match
        load_data_in <= ~w;
    endtask
endmodule

// *** dv/bpcf_properties.sv ***
// checker on the top ports: loads reach fields, host leaves load-only fields alone
// assumes: one clock, async active-low reset
module bpcf_properties (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // load and fields
    input wire logic load_valid_in,
    input wire logic [15:0] load_data_in,
    input wire logic conv1_clock_invert_out,
    input wire logic conv2_clock_invert_out,
    input wire logic conv4_clock_invert_out,
    input wire logic [1:0] conv1_output_cap_range_out,
    input wire logic [1:0] conv4_output_cap_range_out,
    input wire logic [1:0] conv1_switch_rate_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // fields lag the load by register plus output stage
    sequence s_ld; load_valid_in ##1 1'b1; endsequence
    property p_ph4; s_ld |=> conv4_clock_invert_out == $past(load_data_in[15], 2); endproperty
    a_ph4: assert property (p_ph4) else $error("phase 4 wrong");
    property p_ph2; s_ld |=> conv2_clock_invert_out == $past(load_data_in[13], 2); endproperty
    a_ph2: assert property (p_ph2) else $error("phase 2 wrong");
    property p_ph1; s_ld |=> conv1_clock_invert_out == $past(load_data_in[12], 2); endproperty
    a_ph1: assert property (p_ph1) else $error("phase 1 wrong");
    property p_rst; $rose(reset_n_in) |-> conv2_clock_invert_out && !conv1_clock_invert_out
        && !conv4_clock_invert_out && conv4_output_cap_range_out == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
    property p_cap4; s_ld |=> conv4_output_cap_range_out == $past(load_data_in[11:10], 2);
    endproperty
    a_cap4: assert property (p_cap4) else $error("cap 4 wrong");
    property p_cap1; s_ld |=> conv1_output_cap_range_out == $past(load_data_in[5:4], 2);
    endproperty
    a_cap1: assert property (p_cap1) else $error("cap 1 wrong");
    property p_rate; s_ld |=> conv1_switch_rate_out == $past(load_data_in[1:0], 2); endproperty
    a_rate: assert property (p_rate) else $error("rate 1 wrong");
    property p_keep; !$past(load_valid_in, 2) |-> $stable({conv4_output_cap_range_out,
        conv1_output_cap_range_out, conv1_switch_rate_out}); endproperty
    a_keep: assert property (p_keep) else $error("load-only field moved");
endmodule

// *** dv/buck_converter_boot_setup_reg_tb.sv ***
// bench: axi4-lite host accesses and boot loads, checked on bus and fields
// assumes: bpcf_top with bpcf_boot_model on the load bus
`include "bpcf_consts.vh"
module buck_converter_boot_setup_reg_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, reset_n_in = 1'b0, s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic [17:0] s_axi_awaddr_in = 18'h0, s_axi_araddr_in = 18'h0;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in = 4'h0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, load_valid_in, external_eeprom_config_in, load_from_eeprom_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, conv1_switch_rate_out, conv2_switch_rate_out;
    logic [15:0] load_data_in, w;
    logic conv1_clock_invert_out, conv2_clock_invert_out;
    logic conv3_clock_invert_out, conv4_clock_invert_out;
    logic [1:0] conv1_output_cap_range_out, conv2_output_cap_range_out;
    logic [1:0] conv3_output_cap_range_out, conv4_output_cap_range_out;
    int n_mismatch = 0, cmp_count = 0;
    wire [15:0] fld = {conv4_clock_invert_out, conv3_clock_invert_out, conv2_clock_invert_out,
        conv1_clock_invert_out, conv4_output_cap_range_out, conv3_output_cap_range_out,
        conv2_output_cap_range_out, conv1_output_cap_range_out, conv2_switch_rate_out,
        conv1_switch_rate_out};
    always #10 clk_in = ~clk_in;
    bpcf_top i_dut (.*);
    bpcf_boot_model i_boot (.*);
    task automatic final_report;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        @(posedge clk_in);
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        {s_axi_awaddr_in, s_axi_wdata_in, s_axi_wstrb_in} <= {a, d, s};
        repeat (50) begin
            @(posedge clk_in);
            if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
            if (s_axi_bvalid_out === 1'b1) break;
        end
        if (s_axi_bvalid_out !== 1'b1) n_mismatch++;
        if (s_axi_bvalid_out !== 1'b1) final_report;
        chk("bresp", er, s_axi_bresp_out);
        s_axi_bready_in <= 1'b0;
    endtask
    task automatic rd(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk_in);
        {s_axi_arvalid_in, s_axi_rready_in, s_axi_araddr_in} <= {2'h3, a};
        repeat (50) begin
            @(posedge clk_in);
            if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
            if (s_axi_rvalid_out === 1'b1) break;
        end
        if (s_axi_rvalid_out !== 1'b1) n_mismatch++;
        if (s_axi_rvalid_out !== 1'b1) final_report;
        chk("rdata", e, s_axi_rdata_out);
        chk("rresp", er, s_axi_rresp_out);
        s_axi_rready_in <= 1'b0;
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd(`BPCF_SETUP_ADDR, 32'h2000, 2'h0);
        chk("fields", 32'h2000, fld);
        for (int i = 12; i < 16; i++) begin
            wr(`BPCF_SETUP_ADDR, 32'hFFFF0FFF | (32'h1 << i), 4'hF, 2'h0);
            repeat (2) @(posedge clk_in);
            chk("fields", 32'h1 << i, fld);
        end
        // low strobe alone carries no phase bit
        wr(`BPCF_SETUP_ADDR, 32'h0000F000, 4'h1, 2'h0);
        rd(`BPCF_SETUP_ADDR, 32'h8000, 2'h0);
        for (int j = 0; j < 2; j++) begin
            w = j ? 16'h2265 : 16'h5FA9;
            i_boot.load(w, !j[0]);
            repeat (2) @(posedge clk_in);
            chk("fields", w, fld);
            chk("source", !j[0], load_from_eeprom_out);
            wr(`BPCF_SETUP_ADDR, ~w, 4'hF, 2'h0);
            rd(`BPCF_SETUP_ADDR, {~w[15:12], w[11:0]}, 2'h0);
        end
        // boot load collides with a held host write: load lands, phase bits follow
        fork
            wr(`BPCF_SETUP_ADDR, 32'h0000A000, 4'hF, 2'h0);
            begin
                @(posedge clk_in);
                i_boot.load(16'h5AA6, 1'b0);
            end
        join
        rd(`BPCF_SETUP_ADDR, 32'hAAA6, 2'h0);
        wr(`BPCF_SETUP_ADDR + 18'h4, 32'hFFFF, 4'hF, 2'h2);
        rd(`BPCF_SETUP_ADDR + 18'h4, 32'h0, 2'h2);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd(`BPCF_SETUP_ADDR, 32'h2000, 2'h0);
        final_report;
    end
endmodule
bind bpcf_top bpcf_properties i_chk (.*);
